// File: inc/prescale_pkg.sv
// Constants for the reference input prescaler and its register bus.
// Assumes one 10 MHz clock and an AXI4-Lite master with 32-bit data.
package prescale_pkg;
	localparam int addr_w = 4;
	localparam int ratio_w = 20;
	localparam int num_inputs = 4;
	// Byte offsets of the registers
	localparam logic [3:0] cfg_base = 4'h0;
	localparam logic [3:0] status_off = 4'hC;
	// Field positions of the config word
	localparam int prio_bit = 24;
	localparam int hold_n_bit = 22;
	localparam int enable_n_bit = 21;
	localparam int skip_bit = 20;
	localparam int ratio_msb = 19;
	// Reset value, write mask, minimum ratio and response codes
	localparam logic [31:0] cfg_reset = 32'h0050_0000;
	localparam logic [31:0] cfg_rw_mask = 32'h0170_0000 | 32'h000F_FFFF;
	localparam logic [ratio_w-1:0] ratio_min = 20'h00002;
	localparam logic [1:0] resp_okay = 2'h0;
	localparam logic [1:0] resp_slverr = 2'h2;
endpackage

// File: logic/input_divider.sv
// One reference input divider with hold, enable and skip controls.
// Assumes the reference is sampled as an ordinary input on mclk.
`timescale 1ns/100ps
module input_divider (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst,
	// Reference and controls
	input wire logic ref_in,
	input wire logic hold_n,
	input wire logic enable_n,
	input wire logic divider_skip,
	input wire logic [19:0] divide_factor,
	// Result to loop and monitor
	output logic ref_out
);
	logic ref_d_r, ref_d_nxt;
	logic [19:0] cnt_r, cnt_nxt;
	logic div_r, div_nxt;
	logic out_r, out_nxt;
	logic rise;
	logic [19:0] half;

	always_comb begin
		rise = ref_in & ~ref_d_r;
		half = divide_factor >> 1;
		ref_d_nxt = ref_in;
		cnt_nxt = cnt_r;
		div_nxt = div_r;
		if (!hold_n) begin
			// Held in set state
			cnt_nxt = 20'h00000;
			div_nxt = 1'b1;
		end else if (!enable_n && rise) begin
			if (cnt_r >= divide_factor - 20'h00001) begin
				cnt_nxt = 20'h00000;
				div_nxt = 1'b1;
			end else begin
				cnt_nxt = cnt_r + 20'h00001;
				if (cnt_r + 20'h00001 == half)
					div_nxt = 1'b0;
			end
		end
		out_nxt = divider_skip ? ref_in : div_r;
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			ref_d_r <= 1'b0;
			cnt_r <= 20'h00000;
			div_r <= 1'b1;
			out_r <= 1'b0;
		end else begin
			ref_d_r <= ref_d_nxt;
			cnt_r <= cnt_nxt;
			div_r <= div_nxt;
			out_r <= out_nxt;
		end
	end

	assign ref_out = out_r;
endmodule

// File: logic/reference_input_prescaler.sv
// Four reference input prescalers with AXI4-Lite config and selection.
// Assumes references are synchronous to mclk and below half its rate.
//
// What this block does
// - Priority bit 0 first, 1 second.
// - Equal priority: lowest input index wins.
// - Hold bit low keeps divider set.
// - Enable bit low runs the divider.
// - Skip passes reference; else divided reference.
// - Ratio in bits 19:0, minimum two.
// - Reset: skip, hold one, enable zero.
//
// The AXI4-Lite slave port and the placing of the registers are this design's own decisions.
`timescale 1ns/100ps
module reference_input_prescaler (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst,
	// AXI4-Lite write
	input wire logic [3:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read
	input wire logic [3:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// References in and out
	input wire logic [3:0] ref_in,
	output logic [3:0] ref_to_loop,
	output logic [1:0] digital_loop_sel
);
	// One config word per input; the word index is the input number
	logic [31:0] cfg_r [4];
	logic [31:0] cfg_nxt [4];

	// Write channel
	logic [3:0] aw_a_r;
	logic [3:0] aw_a_nxt;
	logic [31:0] w_d_r;
	logic [31:0] w_d_nxt;
	logic [3:0] w_s_r;
	logic [3:0] w_s_nxt;
	logic [1:0] bresp_r;
	logic [1:0] bresp_nxt;
	logic awready_r;
	logic awready_nxt;
	logic wready_r;
	logic wready_nxt;
	logic [31:0] wm;
	logic [1:0] widx;

	// Read channel
	logic [31:0] rdata_r;
	logic [31:0] rdata_nxt;
	logic [1:0] rresp_r;
	logic [1:0] rresp_nxt;
	logic [1:0] ridx;

	// Divider controls and selection
	logic [1:0] sel_r;
	logic [1:0] sel_nxt;
	logic [3:0] div_out;
	logic [3:0] cand;
	logic found;
	logic [3:0] hold_n;
	logic [3:0] enable_n;
	logic [3:0] skip;
	logic [3:0] low_prio;
	logic [prescale_pkg::ratio_w-1:0] raw_ratio [4];
	logic [prescale_pkg::ratio_w-1:0] factor [4];

	// Write side: both halves, one commit cycle, then the answer
	typedef enum logic [4:0] {
		wr_idle = 5'h01,
		wr_got_addr = 5'h02,
		wr_got_data = 5'h04,
		wr_commit = 5'h08,
		wr_answer = 5'h10
	} wr_state_t;
	wr_state_t wr_state_r;
	wr_state_t wr_state_nxt;

	// Read side: an accepted address is answered on the next cycle
	typedef enum logic [1:0] {
		rd_idle = 2'h1,
		rd_answer = 2'h2
	} rd_state_t;
	rd_state_t rd_state_r;
	rd_state_t rd_state_nxt;

	// Ratios below the minimum would wrap the divider's counter
	function automatic logic [prescale_pkg::ratio_w-1:0] clamp_ratio(
		input logic [prescale_pkg::ratio_w-1:0] value
	);
		if (value < prescale_pkg::ratio_min)
			return prescale_pkg::ratio_min;
		return value;
	endfunction

	genvar g;
	generate
		for (g = 0; g < prescale_pkg::num_inputs; g++) begin : gen_div
			assign raw_ratio[g] = cfg_r[g][prescale_pkg::ratio_msb:0];
			assign factor[g] = clamp_ratio(raw_ratio[g]);
			assign hold_n[g] = cfg_r[g][prescale_pkg::hold_n_bit];
			assign enable_n[g] = cfg_r[g][prescale_pkg::enable_n_bit];
			assign skip[g] = cfg_r[g][prescale_pkg::skip_bit];
			assign low_prio[g] = ~cfg_r[g][prescale_pkg::prio_bit];
			input_divider u_div (
				.mclk(mclk),
				.rst(rst),
				.ref_in(ref_in[g]),
				.hold_n(hold_n[g]),
				.enable_n(enable_n[g]),
				.divider_skip(skip[g]),
				.divide_factor(factor[g]),
				.ref_out(div_out[g])
			);
		end
	endgenerate

	// Byte strobes widen to lane masks; read-only bits never change
	generate
		for (g = 0; g < 4; g++) begin : gen_lane
			assign wm[g*8 +: 8] = {8{w_s_r[g]}}
				& prescale_pkg::cfg_rw_mask[g*8 +: 8];
		end
	endgenerate

	always_comb begin
		wr_state_nxt = wr_state_r;
		aw_a_nxt = aw_a_r;
		w_d_nxt = w_d_r;
		w_s_nxt = w_s_r;
		bresp_nxt = bresp_r;
		for (int i = 0; i < 4; i++)
			cfg_nxt[i] = cfg_r[i];
		widx = aw_a_r[3:2];
		unique case (wr_state_r)
			wr_idle: begin
				if (s_axi_awvalid)
					aw_a_nxt = s_axi_awaddr;
				if (s_axi_wvalid) begin
					w_d_nxt = s_axi_wdata;
					w_s_nxt = s_axi_wstrb;
				end
				if (s_axi_awvalid && s_axi_wvalid)
					wr_state_nxt = wr_commit;
				else if (s_axi_awvalid)
					wr_state_nxt = wr_got_addr;
				else if (s_axi_wvalid)
					wr_state_nxt = wr_got_data;
			end
			wr_got_addr: begin
				// Address taken: wait for the data
				if (s_axi_wvalid) begin
					w_d_nxt = s_axi_wdata;
					w_s_nxt = s_axi_wstrb;
					wr_state_nxt = wr_commit;
				end
			end
			wr_got_data: begin
				// Data taken: wait for the address
				if (s_axi_awvalid) begin
					aw_a_nxt = s_axi_awaddr;
					wr_state_nxt = wr_commit;
				end
			end
			wr_commit: begin
				cfg_nxt[widx] = (cfg_r[widx] & ~wm) | (w_d_r & wm);
				bresp_nxt = prescale_pkg::resp_okay;
				wr_state_nxt = wr_answer;
			end
			wr_answer: begin
				// Hold the answer until the master takes it
				if (s_axi_bready)
					wr_state_nxt = wr_idle;
			end
			default: wr_state_nxt = wr_idle;
		endcase
		awready_nxt = wr_state_nxt[0] | wr_state_nxt[2];
		wready_nxt = wr_state_nxt[0] | wr_state_nxt[1];
	end

	// Read path: word index selects an input's config word
	always_comb begin
		rd_state_nxt = rd_state_r;
		rdata_nxt = rdata_r;
		rresp_nxt = rresp_r;
		ridx = s_axi_araddr[3:2];
		unique case (rd_state_r)
			rd_idle: begin
				if (s_axi_arvalid) begin
					rdata_nxt = cfg_r[ridx];
					rresp_nxt = prescale_pkg::resp_okay;
					// Misaligned reads answer with an error
					if (s_axi_araddr[1:0] != 2'h0)
						rresp_nxt = prescale_pkg::resp_slverr;
					rd_state_nxt = rd_answer;
				end
			end
			rd_answer: begin
				// Hold the answer until the master takes it
				if (s_axi_rready)
					rd_state_nxt = rd_idle;
			end
			default: rd_state_nxt = rd_idle;
		endcase
	end

	// Reference choice: first priority class, then lowest index
	always_comb begin
		found = 1'b0;
		sel_nxt = sel_r;
		cand = low_prio;
		// No first-priority input: fall back to all of them
		if (cand == 4'h0)
			cand = 4'hF;
		for (int i = 0; i < 4; i++) begin
			if (cand[i] && !found) begin
				sel_nxt = 2'(i);
				found = 1'b1;
			end
		end
	end

	// Config words and write channel
	always_ff @(posedge mclk) begin
		if (rst) begin
			for (int i = 0; i < 4; i++)
				cfg_r[i] <= prescale_pkg::cfg_reset;
			wr_state_r <= wr_idle;
			aw_a_r <= 4'h0;
			w_d_r <= 32'h0000_0000;
			w_s_r <= 4'h0;
			bresp_r <= 2'h0;
			awready_r <= 1'b1;
			wready_r <= 1'b1;
		end else begin
			for (int i = 0; i < 4; i++)
				cfg_r[i] <= cfg_nxt[i];
			wr_state_r <= wr_state_nxt;
			aw_a_r <= aw_a_nxt;
			w_d_r <= w_d_nxt;
			w_s_r <= w_s_nxt;
			bresp_r <= bresp_nxt;
			awready_r <= awready_nxt;
			wready_r <= wready_nxt;
		end
	end

	// Read channel
	always_ff @(posedge mclk) begin
		if (rst) begin
			rd_state_r <= rd_idle;
			rdata_r <= 32'h0000_0000;
			rresp_r <= 2'h0;
		end else begin
			rd_state_r <= rd_state_nxt;
			rdata_r <= rdata_nxt;
			rresp_r <= rresp_nxt;
		end
	end

	// Selected reference
	always_ff @(posedge mclk) begin
		if (rst)
			sel_r <= 2'h0;
		else
			sel_r <= sel_nxt;
	end

	// Outputs come straight from registers
	assign s_axi_awready = awready_r;
	assign s_axi_wready = wready_r;
	assign s_axi_bvalid = wr_state_r[4];
	assign s_axi_bresp = bresp_r;
	assign s_axi_arready = rd_state_r[0];
	assign s_axi_rvalid = rd_state_r[1];
	assign s_axi_rdata = rdata_r;
	assign s_axi_rresp = rresp_r;
	assign ref_to_loop = div_out;
	assign digital_loop_sel = sel_r;
endmodule

// File: dv/prescaler_checker.sv
// Port assertions for the reference input prescaler.
// Assumes config words keep reset values until the first write.
`timescale 1ns/100ps
module prescaler_checker (
	input wire logic mclk, rst, s_axi_awvalid, s_axi_awready,
	input wire logic s_axi_wvalid, s_axi_wready, s_axi_bvalid,
	input wire logic s_axi_bready, s_axi_arvalid, s_axi_arready,
	input wire logic s_axi_rvalid, s_axi_rready,
	input wire logic [1:0] s_axi_bresp, digital_loop_sel,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [3:0] ref_in, ref_to_loop
);
	logic wr_r;
	always_ff @(posedge mclk) wr_r <= !rst && (wr_r || s_axi_awvalid);
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	a_rst_quiet: assert property (disable iff (1'b0)
		rst |=> !s_axi_bvalid && ref_to_loop == 4'h0 && digital_loop_sel == 2'h0)
		else $error("outputs not quiet after reset");
	a_skip_pass: assert property (!wr_r && !$past(rst)
		|-> ref_to_loop == $past(ref_in)) else $error("skip not passing");
	a_sel_first: assert property (!wr_r |-> digital_loop_sel == 2'h0)
		else $error("default selection wrong");
	a_b_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
		&& s_axi_wready |-> ##[1:2] s_axi_bvalid) else $error("no write answer");
	a_r_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("no read answer");
	a_r_hold: assert property (s_axi_rvalid && !s_axi_rready
		|=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read dropped");
	a_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while busy");
	a_b_okay: assert property (s_axi_bvalid
		|-> s_axi_bresp == prescale_pkg::resp_okay) else $error("write error");
	cover property (s_axi_bvalid && s_axi_bready);
	cover property (digital_loop_sel == 2'h3);
	cover property ($rose(ref_to_loop[1]) && wr_r);
endmodule
bind reference_input_prescaler prescaler_checker i_chk (.*);

// File: dv/ref_source.sv
// Free-running reference clocks for all four inputs.
// Assumes mclk is the bench clock; references toggle on its edges.
`timescale 1ns/100ps
module ref_source #(parameter int half = 3) (
	input wire logic mclk,
	output logic [3:0] ref_in
);
	int cnt_r = 0;
	initial ref_in = 4'h0;
	// Far below 5 MHz, half of mclk, so skip and small ratios are legal
	always @(posedge mclk) begin
		cnt_r <= (cnt_r == half - 1) ? 0 : cnt_r + 1;
		if (cnt_r == half - 1) ref_in <= ~ref_in;
	end
endmodule

// File: dv/reference_input_prescaler_bench.sv
// Self-checking bench for the reference input prescaler.
// Assumes ref_source and the checker bind are compiled with it.
`timescale 1ns/100ps
module reference_input_prescaler_bench;
	localparam int half = 3;
	logic mclk = 0, rst = 1, s_axi_awvalid = 0, s_axi_wvalid = 0;
	logic s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
	logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp, digital_loop_sel;
	logic [3:0] ref_in, ref_to_loop;
	int fail_count = 0, num_checks = 0;
	reference_input_prescaler i_dut (.*);
	ref_source #(.half(half)) i_src (.mclk(mclk), .ref_in(ref_in));
	always #50 mclk = ~mclk;
	task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic summarize;
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	task automatic wr(logic [3:0] a, logic [31:0] d);
		bit ap, dp;
		ap = 1;
		dp = 1;
		@(posedge mclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		s_axi_bready <= 1;
		while (ap || dp || !s_axi_bvalid) begin
			@(posedge mclk);
			if (s_axi_awready) s_axi_awvalid <= 0;
			if (s_axi_wready) s_axi_wvalid <= 0;
			ap = ap && !s_axi_awready;
			dp = dp && !s_axi_wready;
		end
		s_axi_bready <= 0;
	endtask
	task automatic rd(logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge mclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1;
		s_axi_rready <= 1;
		do @(posedge mclk); while (!s_axi_arready);
		s_axi_arvalid <= 0;
		while (!s_axi_rvalid) @(posedge mclk);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 0;
	endtask
	// Counts rising output edges of input one and the last gap between them
	task automatic rises(int cyc, output int e, output int gap);
		int last;
		logic p;
		e = 0;
		last = 0;
		gap = 0;
		p = ref_to_loop[1];
		for (int k = 1; k <= cyc; k++) begin
			@(posedge mclk);
			if (ref_to_loop[1] && !p) begin
				if (e > 0) gap = k - last;
				e++;
				last = k;
			end
			p = ref_to_loop[1];
		end
	endtask
	task automatic t_regs;
		logic [31:0] d;
		logic [1:0] r;
		rd(4'h8, d, r);
		check("cfg2 reset", d, prescale_pkg::cfg_reset);
		rd(4'h2, d, r);
		check("misaligned resp", r, prescale_pkg::resp_slverr);
		wr(4'h8, 32'hFFFF_FFFF);
		rd(4'h8, d, r);
		check("cfg2 masked", d, prescale_pkg::cfg_rw_mask);
	endtask
	task automatic t_prio;
		wr(4'h0, 32'h0150_0000);
		repeat (2) @(posedge mclk);
		check("sel a", digital_loop_sel, 2'h1);
		wr(4'h4, 32'h0150_0000);
		repeat (2) @(posedge mclk);
		check("sel b", digital_loop_sel, 2'h3);
		wr(4'hC, 32'h0150_0000);
		repeat (2) @(posedge mclk);
		check("sel c", digital_loop_sel, 2'h0);
	endtask
	// Every input is in skip here: each output trails its pin by one cycle
	task automatic t_skip;
		logic [3:0] p;
		p = ref_in;
		repeat (12) begin
			@(posedge mclk);
			check("skip pass", ref_to_loop, p);
			p = ref_in;
		end
	endtask
	task automatic t_divide;
		int e, g;
		wr(4'h4, 32'h0140_0004);
		rises(120, e, g);
		check("gap ratio 4", g, 4 * 2 * half);
		wr(4'h4, 32'h0140_0002);
		rises(120, e, g);
		check("gap ratio 2", g, 2 * 2 * half);
		wr(4'h4, 32'h0100_0002);
		repeat (4) @(posedge mclk);
		rises(60, e, g);
		check("held edges", e, 32'h0);
		wr(4'h4, 32'h0160_0002);
		repeat (4) @(posedge mclk);
		rises(60, e, g);
		check("stopped edges", e, 32'h0);
	endtask
	initial begin
		repeat (2) @(posedge mclk);
		rst <= 0;
		t_regs();
		t_prio();
		t_skip();
		t_divide();
		summarize();
	end
	initial begin
		#400000;
		fail_count++;
		summarize();
	end
endmodule
